// >>> core/iob_block.v
// three-cell pin block with its configuration registers on AXI4-Lite
//
// The register offsets and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
`include "iob_map.vh"
module iob_block
(
  // clock and reset
  input  wire                   aclk,
  input  wire                   aresetn,
  // axi4-lite write address
  input  wire [`IOB_ADDR_W-1:0] s_axi_awaddr,
  input  wire [2:0]             s_axi_awprot,
  input  wire                   s_axi_awvalid,
  output wire                   s_axi_awready,
  // axi4-lite write data
  input  wire [31:0]            s_axi_wdata,
  input  wire [3:0]             s_axi_wstrb,
  input  wire                   s_axi_wvalid,
  output wire                   s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]             s_axi_bresp,
  output reg                    s_axi_bvalid,
  input  wire                   s_axi_bready,
  // axi4-lite read address
  input  wire [`IOB_ADDR_W-1:0] s_axi_araddr,
  input  wire [2:0]             s_axi_arprot,
  input  wire                   s_axi_arvalid,
  output wire                   s_axi_arready,
  // axi4-lite read data
  output reg  [31:0]            s_axi_rdata,
  output reg  [1:0]             s_axi_rresp,
  output reg                    s_axi_rvalid,
  input  wire                   s_axi_rready,
  // dedicated pin clocks, as tick enables
  input  wire [5:0]             io_clk,
  // fabric data and control, one line per cell
  input  wire [2:0]             io_dataout,
  input  wire [2:0]             io_coe,
  input  wire [2:0]             io_cce_in,
  input  wire [2:0]             io_cce_out,
  input  wire [2:0]             io_cclk,
  input  wire [2:0]             io_caclr,
  input  wire [2:0]             io_csclr,
  // inputs back to fabric
  output wire [2:0]             io_datain,
  output wire [2:0]             comb_io_datain,
  // pins
  input  wire [2:0]             pin_in,
  output wire [2:0]             pin_out,
  output wire [2:0]             pin_oe_n
);

  // register index from a byte address; low two bits are ignored
  function [2:0] reg_index;
    input [`IOB_ADDR_W-1:0] addr;
    begin
      case ({addr[`IOB_ADDR_W-1:2], 2'b00})
        `IOB_OFS_CELL0: reg_index = 3'h0;
        `IOB_OFS_CELL1: reg_index = 3'h1;
        `IOB_OFS_CELL2: reg_index = 3'h2;
        `IOB_OFS_CTRL:  reg_index = 3'h3;
        `IOB_OFS_STAT:  reg_index = 3'h4;
        default:        reg_index = 3'h7;
      endcase
    end
  endfunction

  // merge write data into an old word under the byte strobes
  function [31:0] strobe_merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0]  strb;
    integer      b;
    begin
      strobe_merge = old;
      for (b = 0; b < 4; b = b + 1)
        if (strb[b])
          strobe_merge[b*8 +: 8] = data[b*8 +: 8];
    end
  endfunction

  reg [`IOB_CFG_W-1:0]          cfg [0:`IOB_CELLS-1];
  reg [`IOB_ADDR_W-1:0]         aw_addr;
  reg                           aw_held;
  reg [31:0]                    w_data;
  reg [3:0]                     w_strb;
  reg                           w_held;
  reg                           init_load;
  reg [31:0]                    next_rdata;
  reg [1:0]                     next_rresp;
  reg [31:0]                    wr_word;
  wire [`IOB_STAT_W-1:0]        cell_state [0:`IOB_CELLS-1];
  wire [31:0]                   stat_word;
  wire [2:0]                    wr_idx;
  wire [2:0]                    rd_idx;
  wire                          wr_fire;
  wire [31:0]                   wr_merged;

  // address and data are taken in either order; no new one while
  // the response is pending, so at most one write is ever in flight
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign wr_fire       = aw_held & w_held & ~s_axi_bvalid;
  assign wr_idx        = reg_index(aw_addr);
  assign rd_idx        = reg_index(s_axi_araddr);
  assign wr_merged     = strobe_merge(wr_word, w_data, w_strb);

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_addr <= {`IOB_ADDR_W{1'b0}};
      aw_held <= 1'b0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_addr <= s_axi_awaddr;
      aw_held <= 1'b1;
    end
    else if (wr_fire)
      aw_held <= 1'b0;
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      w_held <= 1'b0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
      w_held <= 1'b1;
    end
    else if (wr_fire)
      w_held <= 1'b0;
  end

  // old word of the addressed cell, for strobe merging
  always @*
  begin
    wr_word = 32'h00000000;
    if (wr_idx < 3'h3)
      wr_word[`IOB_CFG_W-1:0] = cfg[wr_idx[1:0]];
  end

  // configuration store; the done bit only pulses the initial load
  genvar c;
  generate
    for (c = 0; c < `IOB_CELLS; c = c + 1)
    begin : g_cfg
      always @(posedge aclk)
      begin
        if (!aresetn)
          cfg[c] <= `IOB_CFG_RST;
        else if (wr_fire && wr_idx == c)
          cfg[c] <= wr_merged[`IOB_CFG_W-1:0];
      end
    end
  endgenerate

  always @(posedge aclk)
  begin
    if (!aresetn)
      init_load <= 1'b0;
    else
      init_load <= wr_fire && wr_idx == 3'h3 && w_strb[0] &&
                   w_data[`IOB_F_DONE];
  end

  // write response one cycle after both halves are held
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `IOB_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wr_idx == 3'h7) ? `IOB_RESP_SLVERR
                                       : `IOB_RESP_OKAY;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // read mux; status is read-only and writes to it are ignored
  always @*
  begin
    next_rdata = 32'h00000000;
    next_rresp = `IOB_RESP_OKAY;
    case (rd_idx)
      3'h0, 3'h1, 3'h2: next_rdata[`IOB_CFG_W-1:0] = cfg[rd_idx[1:0]];
      3'h3:             next_rdata = 32'h00000000;
      3'h4:             next_rdata = stat_word;
      default:          next_rresp = `IOB_RESP_SLVERR;
    endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `IOB_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rresp;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // the cells themselves; each has its own seven fabric lines
  generate
    for (c = 0; c < `IOB_CELLS; c = c + 1)
    begin : g_cell
      iob_cell u_cell
      (
        .aclk           (aclk),
        .aresetn        (aresetn),
        .cfg            (cfg[c]),
        .init_load      (init_load),
        .io_clk         (io_clk),
        .io_cclk        (io_cclk[c]),
        .io_cce_in      (io_cce_in[c]),
        .io_cce_out     (io_cce_out[c]),
        .io_caclr       (io_caclr[c]),
        .io_csclr       (io_csclr[c]),
        .io_dataout     (io_dataout[c]),
        .io_coe         (io_coe[c]),
        .io_datain      (io_datain[c]),
        .comb_io_datain (comb_io_datain[c]),
        .pin_in         (pin_in[c]),
        .pin_out        (pin_out[c]),
        .pin_oe_n       (pin_oe_n[c]),
        .state          (cell_state[c])
      );
      assign stat_word[c*`IOB_STAT_STRIDE +: `IOB_STAT_STRIDE] =
        {3'h0, cell_state[c]};
    end
  endgenerate

  assign stat_word[31:`IOB_CELLS*`IOB_STAT_STRIDE] = 8'h00;

endmodule // iob_block

// >>> core/iob_map.vh
// constants of the three-cell programmable pin block
// Functional notes
// - block accepts 21 fabric lines, seven per cell, one of each kind.
// - each cell returns one registered-or-direct input and one direct input.
// - six dedicated pin clocks are offered to every cell as clock choices.
// - each cell selects its own oe, enables, clear, sync clear, clocks.
// - input register has clock and enable chosen apart from output side.
// - output and oe registers share one clock and one clock enable.
// - each cell holds input, output and output-enable registers and two delay lines.
// - two direct input paths per cell, each with its own delay setting.
// - differing direct path delays make the input register unavailable.
// - delay settings exist for pin-fabric, pin-register and register-pin.
// - one clear-or-preset source per cell; clear or preset programmable.
// - registers take a programmed high or low value at config done.
// - low-initialised registers clear, high-initialised ones preset.
// - per-cell selectable synchronous clear acting on the clock edge.
// - pin data reaches fabric; fabric drives all cell inputs.
// - block holds up to three cells with their own connections.
`ifndef IOB_MAP_VH
`define IOB_MAP_VH

`define IOB_CELLS       3
`define IOB_DED_CLKS    6
`define IOB_ADDR_W      8
`define IOB_CFG_W       27
`define IOB_CFG_RST     27'h0000000
`define IOB_DLY_TAPS    7

// register byte offsets
`define IOB_OFS_CELL0   8'h00
`define IOB_OFS_CELL1   8'h04
`define IOB_OFS_CELL2   8'h08
`define IOB_OFS_CTRL    8'h0c
`define IOB_OFS_STAT    8'h10

// cell configuration fields
`define IOB_F_CKIN      2:0
`define IOB_F_CKOUT     5:3
`define IOB_F_CEIN      6
`define IOB_F_CEOUT     7
`define IOB_F_PRESET    8
`define IOB_F_ACLR      9
`define IOB_F_SCLR      10
`define IOB_F_INREG     11
`define IOB_F_OUTREG    12
`define IOB_F_OEREG     13
`define IOB_F_DLYA      17:15
`define IOB_F_DLYB      20:18
`define IOB_F_DLYR      23:21
`define IOB_F_DLYO      26:24

// clock select codes: 0..5 dedicated, then fabric, then every edge
`define IOB_CK_FABRIC   3'h6
`define IOB_CK_SYS      3'h7

// control and status fields
`define IOB_F_DONE      0
`define IOB_STAT_W      5
`define IOB_STAT_STRIDE 8

`define IOB_RESP_OKAY   2'h0
`define IOB_RESP_SLVERR 2'h2

`endif

// >>> core/iob_cell.v
// one programmable pin cell: three registers, clock and control selection
`timescale 1ns/1ps
`include "iob_map.vh"
module iob_cell
(
  // clock and reset
  input  wire                  aclk,
  input  wire                  aresetn,
  // configuration
  input  wire [`IOB_CFG_W-1:0] cfg,
  input  wire                  init_load,
  // clock choices
  input  wire [5:0]            io_clk,
  input  wire                  io_cclk,
  // fabric side
  input  wire                  io_cce_in,
  input  wire                  io_cce_out,
  input  wire                  io_caclr,
  input  wire                  io_csclr,
  input  wire                  io_dataout,
  input  wire                  io_coe,
  output wire                  io_datain,
  output wire                  comb_io_datain,
  // pin side
  input  wire                  pin_in,
  output wire                  pin_out,
  output wire                  pin_oe_n,
  // state for software
  output wire [`IOB_STAT_W-1:0] state
);

  // clocks arrive as one-cycle tick enables on aclk
  function clk_tick;
    input [2:0] sel;
    input [5:0] ded;
    input       fab;
    begin
      case (sel)
        3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5: clk_tick = ded[sel];
        `IOB_CK_FABRIC: clk_tick = fab;
        default: clk_tick = 1'b1;
      endcase
    end
  endfunction

  // tap 0 is the undelayed signal
  function tap;
    input [2:0]               sel;
    input                     now;
    input [`IOB_DLY_TAPS-1:0] line;
    begin
      if (sel == 3'h0)
        tap = now;
      else
        tap = line[sel - 3'h1];
    end
  endfunction

  reg                      in_reg;
  reg                      out_reg;
  reg                      oe_reg;
  reg [`IOB_DLY_TAPS-1:0]  pin_dly;
  reg [`IOB_DLY_TAPS-1:0]  out_dly;

  wire in_edge  = clk_tick(cfg[`IOB_F_CKIN], io_clk, io_cclk);
  wire out_edge = clk_tick(cfg[`IOB_F_CKOUT], io_clk, io_cclk);
  wire in_ce    = ~cfg[`IOB_F_CEIN] | io_cce_in;
  wire out_ce   = ~cfg[`IOB_F_CEOUT] | io_cce_out;
  wire init_val = cfg[`IOB_F_PRESET];
  wire aclr_hit = cfg[`IOB_F_ACLR] & io_caclr;
  wire sclr_hit = cfg[`IOB_F_SCLR] & io_csclr;
  // two differing direct-path delays take the input register away
  wire in_block = cfg[`IOB_F_DLYA] != cfg[`IOB_F_DLYB];
  wire in_use   = cfg[`IOB_F_INREG] & ~in_block;
  wire out_val  = cfg[`IOB_F_OUTREG] ? out_reg : io_dataout;
  wire oe_val   = cfg[`IOB_F_OEREG] ? oe_reg : io_coe;

  // delay lines run every cycle so a setting change takes effect at once
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_dly <= {`IOB_DLY_TAPS{1'b0}};
      out_dly <= {`IOB_DLY_TAPS{1'b0}};
    end
    else
    begin
      pin_dly <= {pin_dly[`IOB_DLY_TAPS-2:0], pin_in};
      out_dly <= {out_dly[`IOB_DLY_TAPS-2:0], out_val};
    end
  end

  // the three cell registers; the two delay lines are the only other storage
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      in_reg  <= 1'b0;
      out_reg <= 1'b0;
      oe_reg  <= 1'b0;
    end
    else if (init_load || aclr_hit)
    begin
      in_reg  <= init_val;
      out_reg <= init_val;
      oe_reg  <= init_val;
    end
    else
    begin
      if (in_edge && sclr_hit)
        in_reg <= init_val;
      else if (in_edge && in_ce && in_use)
        in_reg <= tap(cfg[`IOB_F_DLYR], pin_in, pin_dly);
      if (out_edge && sclr_hit)
      begin
        out_reg <= init_val;
        oe_reg  <= init_val;
      end
      else if (out_edge && out_ce)
      begin
        out_reg <= io_dataout;
        oe_reg  <= io_coe;
      end
    end
  end

  assign io_datain      = in_use ? in_reg :
                          tap(cfg[`IOB_F_DLYA], pin_in, pin_dly);
  assign comb_io_datain = tap(cfg[`IOB_F_DLYB], pin_in, pin_dly);
  assign pin_out        = tap(cfg[`IOB_F_DLYO], out_val, out_dly);
  assign pin_oe_n       = ~oe_val;
  assign state          = {in_block, oe_reg, out_reg, in_reg, pin_in};

endmodule // iob_cell

// >>> tb/iob_monitor.sv
// assertion checker on the register port of the pin block
`timescale 1ns/1ps
`include "iob_map.vh"
module iob_monitor
(
  // clock and reset
  input wire        aclk,
  input wire        aresetn,
  // write channels
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  // read channels
  input wire [7:0]  s_axi_araddr,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready
);
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid
                 && s_axi_wready;
  wire rd_miss = !(s_axi_araddr inside {`IOB_OFS_CELL0, `IOB_OFS_CELL1,
                 `IOB_OFS_CELL2, `IOB_OFS_CTRL, `IOB_OFS_STAT});
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_b_stand: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped or changed while waiting");
  chk_r_stand: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped or changed while waiting");
  chk_ar_block: assert property (
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while data pending");
  chk_aw_block: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  chk_rd_okay: assert property (
    ar_take && !rd_miss |=> s_axi_rvalid && s_axi_rresp == `IOB_RESP_OKAY)
    else $error("mapped read not answered okay in one cycle");
  chk_rd_unmapped: assert property (
    ar_take && rd_miss |=> s_axi_rvalid
    && s_axi_rresp == `IOB_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused with zero data");
  chk_wr_answer: assert property (
    wr_take |-> ##2 s_axi_bvalid)
    else $error("write response not raised two cycles after the take");
  chk_b_release: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response kept after acceptance");
  chk_idle_rst: assert property (
    $rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && s_axi_arready)
    else $error("bus not idle after reset");
  cov_write: cover property (wr_take);
  cov_read:  cover property (ar_take && !rd_miss);
  cov_miss:  cover property (ar_take && rd_miss);
endmodule // iob_monitor

bind iob_block iob_monitor i_mon (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// >>> tb/iob_far_model.sv
// far side: pad with an outside driver and a pull-up
`timescale 1ns/1ps
module iob_far_model
(
  // device side of the pad
  input  wire [2:0] pin_out,
  input  wire [2:0] pin_oe_n,
  // outside driver
  input  wire [2:0] ext_val,
  input  wire [2:0] ext_en,
  // resolved level
  output wire [2:0] pin_in
);
  // outside driver only acts while the device floats, so no contention;
  // nobody driving reads high through the pull-up
  assign pin_in = (~pin_oe_n & pin_out)
                | (pin_oe_n & ~(ext_en & ~ext_val));
endmodule // iob_far_model

// >>> tb/tb.sv
// self-checking bench for the three-cell pin block
`timescale 1ns/1ps
`include "iob_map.vh"
`define CHK(nm, ex, gt) \
  begin \
    compares++; \
    if ((gt) !== (ex)) \
    begin \
      bad_count++; \
      $display("unexpected %s expected %h seen %h", nm, ex, gt); \
    end \
  end
module tb;
  typedef struct { logic [33:0] e; logic [33:0] m; } iob_note_t;
  localparam logic [31:0] f_pre  = 32'h1 << `IOB_F_PRESET;
  localparam logic [31:0] f_aclr = 32'h1 << `IOB_F_ACLR;
  localparam logic [31:0] f_sclr = 32'h1 << `IOB_F_SCLR;
  localparam logic [31:0] f_regs = 32'h7 << `IOB_F_INREG;
  localparam logic [33:0] m2     = {2'h3, 32'he0000};
  logic        aclk, aresetn, awvalid, wvalid, bvalid, bready, arvalid;
  logic        rvalid, rready, awready, wready, arready, pflip, pseen;
  logic        slow;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, seed;
  logic [1:0]  bresp, rresp;
  logic [5:0]  io_clk;
  logic [2:0]  dout, coe, cei, ceo, cclk, caclr, csclr, din, cdin;
  logic [2:0]  pin_in, pin_out, pin_oe_n, ext_val, ext_en;
  int          bad_count, compares;
  logic [1:0]  bq[$];
  iob_note_t   rq[$], pq[$];

  iob_block i_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .io_clk(io_clk), .io_dataout(dout),
    .io_coe(coe), .io_cce_in(cei), .io_cce_out(ceo), .io_cclk(cclk),
    .io_caclr(caclr), .io_csclr(csclr), .io_datain(din),
    .comb_io_datain(cdin), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n));
  iob_far_model i_far (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));

  initial
  begin
    aclk = 0;
    forever #2 aclk = ~aclk;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    logic aw_p, w_p;
    aw_p = 1;
    w_p = 1;
    bq.push_back(r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= !slow;
    while (aw_p || w_p)
    begin
      @(posedge aclk);
      if (aw_p && awready)
      begin
        aw_p = 0;
        awvalid <= 0;
      end
      if (w_p && wready)
      begin
        w_p = 0;
        wvalid <= 0;
      end
    end
    // a slow master leaves the response waiting a while
    if (slow) repeat (2) @(posedge aclk);
    bready <= 1;
    do @(posedge aclk); while (!bvalid);
  endtask

  task automatic rd(input logic [7:0] a, input logic [33:0] e,
                    input logic [33:0] m);
    rq.push_back('{e, m});
    araddr <= a;
    arvalid <= 1;
    rready <= !slow;
    do @(posedge aclk); while (!arready);
    arvalid <= 0;
    if (slow) repeat (2) @(posedge aclk);
    rready <= 1;
    do @(posedge aclk); while (!rvalid);
  endtask

  // pin values are compared at the edge after the probe
  task automatic probe(input logic [11:0] e, input logic [11:0] m);
    pq.push_back('{e, m});
    pflip <= ~pflip;
    @(posedge aclk);
  endtask

  // sel high ticks only clock code k of cell 1; low ticks all others
  task automatic tick(input int k, input logic sel, input logic [2:0] ce);
    logic [5:0] s;
    s = (k < 6) ? 6'h1 << k : 6'h0;
    io_clk <= sel ? s : ~s;
    cclk <= ((k == 6) == sel) ? 3'b010 : 3'b000;
    ceo <= ce;
    @(posedge aclk);
    io_clk <= 0;
    cclk <= 0;
    caclr <= 0;
    csclr <= 0;
  endtask

  task automatic conclude();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge aclk)
  begin : watch
    iob_note_t n;
    logic [1:0] b;
    if (bvalid && bready)
    begin
      b = bq.pop_front();
      `CHK("bresp", b, bresp)
    end
    if (rvalid && rready)
    begin
      n = rq.pop_front();
      `CHK("read", n.e, {rresp, rdata} & n.m)
    end
    if (pflip !== pseen)
    begin
      pseen = pflip;
      n = pq.pop_front();
      `CHK("pins", n.e[11:0], {pin_oe_n, pin_out, din, cdin} & n.m[11:0])
    end
  end

  initial
  begin
    repeat (5000) @(posedge aclk);
    bad_count++;
    $display("unexpected watchdog expired");
    conclude();
  end

  initial
  begin : main
    logic [31:0] c, r;
    int k;
    {aresetn, awvalid, wvalid, bready, arvalid, rready, pflip, pseen} = 0;
    {awaddr, araddr, wdata, io_clk, dout, coe, cei, ceo, cclk} = 0;
    {caclr, csclr, ext_val, ext_en} = 0;
    bad_count = 0;
    compares = 0;
    slow = 1;
    seed = 32'h763c5623;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    for (k = 0; k < 4; k++) rd(8'(k * 4), 0, '1);
    rd(8'h14, {`IOB_RESP_SLVERR, 32'h0}, '1);
    wr(8'h20, 1, `IOB_RESP_SLVERR);
    c = $random(seed);
    wr(`IOB_OFS_CELL0, c, 0);
    rd(`IOB_OFS_CELL0, {7'h0, c[26:0]}, '1);
    wr(`IOB_OFS_CELL0, 0, 0);
    slow = 0;
    $display("test map done");
    repeat (8)
    begin
      r = $random(seed);
      dout <= r[2:0];
      coe <= r[5:3];
      ext_val <= r[8:6];
      ext_en <= r[11:9];
      c[2:0] = (r[5:3] & r[2:0]) | (~r[5:3] & ~(r[11:9] & ~r[8:6]));
      probe({~r[5:3], r[2:0], c[2:0], c[2:0]}, 12'hfff);
    end
    $display("test direct done");
    for (k = 0; k < 7; k++)
    begin
      c = f_aclr | (32'h1 << `IOB_F_CEOUT) | (32'h3 << `IOB_F_OUTREG);
      c[`IOB_F_CKOUT] = k[2:0];
      wr(`IOB_OFS_CELL1, c, 0);
      dout <= 3'b010;
      coe <= 3'b010;
      caclr <= 3'b010;
      @(posedge aclk);
      caclr <= 3'b000;
      // clear first, so the next tick really tests the other clocks
      tick(k, 0, 3'b010);
      probe(12'h400, 12'h480);
      tick(k, 1, 3'b000);
      probe(12'h400, 12'h480);
      tick(k, 1, 3'b010);
      probe(12'h080, 12'h480);
    end
    $display("test clocks done");
    wr(`IOB_OFS_CELL2, f_regs | f_pre | f_aclr, 0);
    wr(`IOB_OFS_CTRL, 1, 0);
    repeat (3) @(posedge aclk);
    rd(`IOB_OFS_STAT, {2'h0, 32'he0000}, m2);
    wr(`IOB_OFS_CELL2, f_regs | f_aclr, 0);
    caclr <= 3'b100;
    tick(0, 0, 0);
    rd(`IOB_OFS_STAT, 0, m2);
    wr(`IOB_OFS_CELL2, f_regs | f_pre | f_sclr, 0);
    caclr <= 3'b100;
    tick(0, 0, 0);
    rd(`IOB_OFS_STAT, 0, m2);
    csclr <= 3'b100;
    tick(0, 1, 0);
    rd(`IOB_OFS_STAT, {2'h0, 32'he0000}, m2);
    $display("test clear done");
    c = 32'h1 << `IOB_F_INREG;
    c[`IOB_F_DLYA] = 3'h1;
    c[`IOB_F_DLYB] = 3'h2;
    wr(`IOB_OFS_CELL0, c, 0);
    rd(`IOB_OFS_STAT, {2'h0, 32'h10}, {2'h3, 32'h10});
    c[`IOB_F_DLYB] = 3'h1;
    wr(`IOB_OFS_CELL0, c, 0);
    rd(`IOB_OFS_STAT, 0, {2'h3, 32'h10});
    wr(`IOB_OFS_CELL0, 32'h2 << 24, 0);
    dout <= 0;
    repeat (4) @(posedge aclk);
    dout <= 3'b001;
    probe(12'h000, 12'h040);
    repeat (3) @(posedge aclk);
    probe(12'h040, 12'h040);
    $display("test delay done");
    wr(`IOB_OFS_CELL0, (32'h1 << `IOB_F_INREG) | (32'h1 << `IOB_F_CEIN)
       | 32'h7, 0);
    ext_en <= 3'b001;
    ext_val <= 3'b001;
    tick(1, 1, 0);
    probe(12'h000, 12'h008);
    cei <= 3'b001;
    tick(1, 1, 0);
    probe(12'h008, 12'h008);
    $display("test input done");
    conclude();
  end
endmodule // tb
